// *** logic/mipe_core.sv ***
// Hart-local machine interrupt pending and enable words with trap selection.
// Assumes the core supplies mode, global enables and the delegation mask, and
// that interrupt sources arrive asynchronously; counter overflow is same-clock.
//
// Function
// - Cause i maps to bit i of both words
// - Machine trap needs gate, pending, enabled, undelegated
// - Trap conditions re-evaluated every cycle after changes
// - Machine interrupts outrank lower-mode interrupts
// - Writing zero clears writable pending bits
// - Enable writable if source exists, else zero
// - Non-maskable interrupt never shown in pending
// - Machine external pending follows controller only
// - Machine timer pending follows timer side only
// - Machine software pending follows mapped registers
// - Software pending/enable may be hardwired zero
// - No supervisor mode: supervisor bits read zero
// - Supervisor external reads software bit OR signal
// - Signal never captured in read-modify-write
// - Supervisor timer pending writable with supervisor mode
// - Supervisor software pending writable, controller sets
// - Counter overflow pending/enable, set by flags
// - Fixed machine priority order, external first
// - Platform causes rank highest, lowest index first
// - Software bits lie in lowest four positions
// - Supervisor views show only delegated causes
// - Both words full width, write-any read-legal
// - Delegation mask shares pending word layout
`timescale 1ns/1ps
`include "mipe_defines.svh"

module mipe_core #(
    parameter bit P_HAS_SMODE = 1'b1,
    parameter bit P_HAS_MSW   = 1'b1,
    parameter bit P_HAS_LCOF  = 1'b1
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    input  wire mipe_pkg::mipe_priv_t      i_priv,
    input  wire logic                      i_mstatus_mie,
    input  wire logic                      i_mstatus_sie,
    input  wire logic [`MIPE_WORD_W-1:0]   i_deleg,
    input  wire logic                      i_csr_valid,
    input  wire mipe_pkg::mipe_sel_t       i_csr_sel,
    input  wire mipe_pkg::mipe_op_t        i_csr_op,
    input  wire logic [`MIPE_WORD_W-1:0]   i_csr_wdata,
    input  wire logic                      i_machine_external_int,
    input  wire logic                      i_machine_timer_int,
    input  wire logic                      i_machine_software_int,
    input  wire logic                      i_supervisor_external_int,
    input  wire logic                      i_supervisor_software_set,
    input  wire logic [`MIPE_PLAT_N-1:0]   i_platform_int,
    input  wire logic                      i_overflow_flag,
    output logic [`MIPE_WORD_W-1:0]        o_csr_rdata,
    output logic [`MIPE_WORD_W-1:0]        o_pending,
    output logic [`MIPE_WORD_W-1:0]        o_enable,
    output logic                           o_m_irq,
    output logic [`MIPE_CAUSE_W-1:0]       o_m_cause,
    output logic                           o_s_irq,
    output logic [`MIPE_CAUSE_W-1:0]       o_s_cause
);
    localparam logic [`MIPE_WORD_W-1:0] S_MASK    = P_HAS_SMODE ? `MIPE_S_MASK : '0;
    localparam logic [`MIPE_WORD_W-1:0] MSW_MASK  = P_HAS_MSW ? `MIPE_MSW_MASK : '0;
    localparam logic [`MIPE_WORD_W-1:0] LCOF_MASK = P_HAS_LCOF ? `MIPE_LCOF_MASK : '0;
    // Software-writable pending bits; machine bits stay read-only here
    localparam logic [`MIPE_WORD_W-1:0] PEND_WR = S_MASK | LCOF_MASK;
    localparam logic [`MIPE_WORD_W-1:0] ENAB_WR = S_MASK | LCOF_MASK | MSW_MASK
                                                | `MIPE_M_STD_MASK | `MIPE_PLAT_MASK;
    // Machine-level causes may not be delegated
    localparam logic [`MIPE_WORD_W-1:0] DELEG_OK = S_MASK | LCOF_MASK;

    // Input synchronisers: three stages, a change counts once stages 2 and 3 agree
    logic [`MIPE_ASYNC_N-1:0] raw;
    logic [`MIPE_ASYNC_N-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;

    assign raw = {i_platform_int, i_supervisor_software_set, i_supervisor_external_int,
                  i_machine_software_int, i_machine_timer_int, i_machine_external_int};

    genvar g;
    generate
        for (g = 0; g < `MIPE_ASYNC_N; g++) begin : g_sync
            always_comb begin
                filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
            end
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    s1_q[g]   <= 1'b0;
                    s2_q[g]   <= 1'b0;
                    s3_q[g]   <= 1'b0;
                    filt_q[g] <= 1'b0;
                end else begin
                    s1_q[g]   <= raw[g];
                    s2_q[g]   <= s1_q[g];
                    s3_q[g]   <= s2_q[g];
                    filt_q[g] <= filt_d[g];
                end
            end
        end
    endgenerate

    logic mei_f, mti_f, msi_f, sei_f, ssi_set_f;
    logic [`MIPE_PLAT_N-1:0] plat_f;
    assign {plat_f, ssi_set_f, sei_f, msi_f, mti_f, mei_f} = filt_q;

    // Stored pending bits (software-owned) and enable word
    logic [`MIPE_WORD_W-1:0] pend_q, pend_d, enab_q, enab_d;
    logic [`MIPE_WORD_W-1:0] pend_eff, deleg_l, rdata;

    assign deleg_l = i_deleg & DELEG_OK;

    // Effective pending word: no non-maskable bit exists in it
    always_comb begin
        pend_eff = pend_q & PEND_WR;
        pend_eff[`MIPE_BIT_MEI] = mei_f;
        pend_eff[`MIPE_BIT_MTI] = mti_f;
        pend_eff[`MIPE_BIT_MSI] = msi_f & P_HAS_MSW;
        pend_eff[`MIPE_BIT_SEI] = (pend_q[`MIPE_BIT_SEI] | sei_f) & P_HAS_SMODE;
        pend_eff[`MIPE_WORD_W-1:`MIPE_PLAT_LO] = plat_f;
    end

    function automatic logic [`MIPE_WORD_W-1:0] apply_op(
        input mipe_pkg::mipe_op_t       op,
        input logic [`MIPE_WORD_W-1:0]  old,
        input logic [`MIPE_WORD_W-1:0]  arg
    );
        unique case (op)
            mipe_pkg::MIPE_OP_WRITE: apply_op = arg;
            mipe_pkg::MIPE_OP_SET:   apply_op = old | arg;
            mipe_pkg::MIPE_OP_CLEAR: apply_op = old & ~arg;
            mipe_pkg::MIPE_OP_READ:  apply_op = old;
        endcase
    endfunction

    always_comb begin
        logic [`MIPE_WORD_W-1:0] wmask;
        wmask  = '0;
        pend_d = pend_q;
        enab_d = enab_q;
        rdata  = '0;
        if (i_csr_valid) begin
            unique case (i_csr_sel)
                mipe_pkg::MIPE_SEL_MPEND: begin
                    rdata = pend_eff;
                    wmask = PEND_WR;
                    // Operand meets the stored bit only, never the line
                    pend_d = (pend_q & ~wmask)
                           | (apply_op(i_csr_op, pend_q, i_csr_wdata) & wmask);
                end
                mipe_pkg::MIPE_SEL_MENAB: begin
                    rdata  = enab_q;
                    enab_d = (enab_q & ~ENAB_WR)
                           | (apply_op(i_csr_op, enab_q, i_csr_wdata) & ENAB_WR);
                end
                mipe_pkg::MIPE_SEL_SPEND: begin
                    rdata = pend_eff & deleg_l;
                    wmask = PEND_WR & deleg_l;
                    pend_d = (pend_q & ~wmask)
                           | (apply_op(i_csr_op, pend_q, i_csr_wdata) & wmask);
                end
                mipe_pkg::MIPE_SEL_SENAB: begin
                    rdata = enab_q & deleg_l;
                    wmask = ENAB_WR & deleg_l;
                    enab_d = (enab_q & ~wmask)
                           | (apply_op(i_csr_op, enab_q, i_csr_wdata) & wmask);
                end
            endcase
        end
        // Hardware sets are applied last so they win over a same-cycle clear
        if (ssi_set_f && P_HAS_SMODE) begin
            pend_d[`MIPE_BIT_SSI] = 1'b1;
        end
        if (i_overflow_flag && P_HAS_LCOF) begin
            pend_d[`MIPE_BIT_LCOF] = 1'b1;
        end
        pend_d = pend_d & PEND_WR;
        enab_d = enab_d & ENAB_WR;
    end

    // Trap selection; platform causes first, lowest index winning
    function automatic logic [`MIPE_CAUSE_W-1:0] pick(input logic [`MIPE_WORD_W-1:0] v);
        logic found;
        logic [`MIPE_CAUSE_W-1:0] ord [7];
        ord = '{`MIPE_CAUSE_W'(`MIPE_BIT_MEI), `MIPE_CAUSE_W'(`MIPE_BIT_MSI),
                `MIPE_CAUSE_W'(`MIPE_BIT_MTI), `MIPE_CAUSE_W'(`MIPE_BIT_SEI),
                `MIPE_CAUSE_W'(`MIPE_BIT_SSI), `MIPE_CAUSE_W'(`MIPE_BIT_STI),
                `MIPE_CAUSE_W'(`MIPE_BIT_LCOF)};
        found = 1'b0;
        pick  = '0;
        for (int i = `MIPE_PLAT_LO; i < `MIPE_WORD_W; i++) begin
            if (v[i] && !found) begin
                pick  = `MIPE_CAUSE_W'(i);
                found = 1'b1;
            end
        end
        for (int k = 0; k < 7; k++) begin
            if (v[ord[k]] && !found) begin
                pick  = ord[k];
                found = 1'b1;
            end
        end
    endfunction

    logic [`MIPE_WORD_W-1:0] m_ready, s_ready;
    logic m_gate, s_gate, m_irq_d, s_irq_d;
    logic [`MIPE_CAUSE_W-1:0] m_cause_d, s_cause_d;

    always_comb begin
        m_gate = (i_priv == mipe_pkg::MIPE_PRIV_M) ? i_mstatus_mie : 1'b1;
        s_gate = (i_priv == mipe_pkg::MIPE_PRIV_S && i_mstatus_sie)
               || i_priv == mipe_pkg::MIPE_PRIV_U;
        m_ready = pend_eff & enab_q & ~deleg_l;
        s_ready = pend_eff & enab_q & deleg_l;
        m_irq_d = m_gate && (|m_ready);
        // A machine-bound interrupt suppresses any supervisor-bound one
        s_irq_d = s_gate && (|s_ready) && !m_irq_d;
        m_cause_d = pick(m_ready);
        s_cause_d = pick(s_ready);
    end

    // Every cycle re-evaluates, so a return is seen one edge later and a register write two edges later
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_q      <= `MIPE_PEND_RST;
            enab_q      <= `MIPE_ENAB_RST;
            o_csr_rdata <= '0;
            o_pending   <= '0;
            o_enable    <= '0;
            o_m_irq     <= 1'b0;
            o_m_cause   <= '0;
            o_s_irq     <= 1'b0;
            o_s_cause   <= '0;
        end else begin
            pend_q      <= pend_d;
            enab_q      <= enab_d;
            o_csr_rdata <= rdata;
            o_pending   <= pend_eff;
            o_enable    <= enab_q;
            o_m_irq     <= m_irq_d;
            o_m_cause   <= m_cause_d;
            o_s_irq     <= s_irq_d;
            o_s_cause   <= s_cause_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_take_matches_gate: assert property (m_gate && (|m_ready) |=> o_m_irq)
        else $error("machine interrupt not taken");
    a_m_over_s: assert property (o_m_irq |-> !o_s_irq)
        else $error("supervisor interrupt beside machine one");
    a_mei_first: assert property (m_gate && m_ready[11] && m_ready[7]
        && !(|m_ready[31:16]) |=> o_m_cause == 5'h0b)
        else $error("external not first");
    a_sei_no_capture: assert property (i_csr_valid
        && i_csr_sel == mipe_pkg::MIPE_SEL_MPEND && i_csr_op == mipe_pkg::MIPE_OP_WRITE
        && P_HAS_SMODE |=> pend_q[9] == $past(i_csr_wdata[9]))
        else $error("line captured into stored bit");
    a_mei_readonly: assert property (##1 o_pending[11] == $past(mei_f))
        else $error("external pending not from line");
    a_clear_supervisor_timer_pending: assert property (i_csr_valid
        && i_csr_sel == mipe_pkg::MIPE_SEL_MPEND && i_csr_op == mipe_pkg::MIPE_OP_CLEAR
        && i_csr_wdata[5] |=> !pend_q[5])
        else $error("pending bit not cleared");
    a_enab_legal: assert property ((enab_q & ~ENAB_WR) == '0)
        else $error("illegal enable bit set");
    a_ovf_sets: assert property (i_overflow_flag && P_HAS_LCOF |=> pend_q[13])
        else $error("overflow pending not raised");
    a_s_view: assert property (i_csr_valid
        && i_csr_sel == mipe_pkg::MIPE_SEL_SPEND |=> (o_csr_rdata & ~$past(deleg_l)) == '0)
        else $error("undelegated bit in supervisor view");
    // Source-owned bits mirror their filtered lines one edge later
    a_mti_readonly: assert property (##1 o_pending[7] == $past(mti_f))
        else $error("timer pending not from line");
    a_msi_readonly: assert property (##1 o_pending[3] == ($past(msi_f) && P_HAS_MSW))
        else $error("software pending not from register");
    a_plat_follow: assert property (##1 o_pending[31:16] == $past(plat_f))
        else $error("platform pending not from lines");
    a_sei_read_or: assert property (i_csr_valid
        && i_csr_sel == mipe_pkg::MIPE_SEL_MPEND && P_HAS_SMODE
        |=> o_csr_rdata[9] == $past(pend_q[9] || sei_f))
        else $error("supervisor external read is not the OR");
    a_ssi_sets: assert property (ssi_set_f && P_HAS_SMODE |=> pend_q[1])
        else $error("software pending set lost");
    a_enab_write: assert property (i_csr_valid
        && i_csr_sel == mipe_pkg::MIPE_SEL_MENAB && i_csr_op == mipe_pkg::MIPE_OP_WRITE
        |=> enab_q == ($past(i_csr_wdata) & ENAB_WR))
        else $error("enable write not legalised");
    a_m_gate_off: assert property (i_priv == mipe_pkg::MIPE_PRIV_M
        && !i_mstatus_mie |=> !o_m_irq)
        else $error("machine interrupt taken while gated");
    // Delegated causes stay masked while the hart runs in machine mode
    a_s_gate_off: assert property (i_priv == mipe_pkg::MIPE_PRIV_M
        || (i_priv == mipe_pkg::MIPE_PRIV_S && !i_mstatus_sie) |=> !o_s_irq)
        else $error("supervisor interrupt taken while gated");

    // Main scenarios the bench is expected to reach
    c_m_trap: cover property (o_m_irq && o_m_cause == 5'h07);
    c_s_trap: cover property (o_s_irq);
    c_sei_or: cover property (sei_f && !pend_q[9] && o_pending[9]);
    c_lcof_trap: cover property (o_m_irq && o_m_cause == 5'h0d);
    c_plat_trap: cover property (o_m_irq && o_m_cause[4]);
endmodule // mipe_core

// *** logic/mipe_defines.svh ***
// Bit positions, masks and reset values of the interrupt pending/enable block.
// Assumes a 32-bit machine word and a core that issues one register access per cycle.
`ifndef MIPE_DEFINES_SVH
`define MIPE_DEFINES_SVH

`define MIPE_WORD_W        32
`define MIPE_CAUSE_W       5
`define MIPE_PLAT_LO       16
`define MIPE_PLAT_N        16
`define MIPE_ASYNC_N       21

`define MIPE_BIT_SSI       1
`define MIPE_BIT_MSI       3
`define MIPE_BIT_STI       5
`define MIPE_BIT_MTI       7
`define MIPE_BIT_SEI       9
`define MIPE_BIT_MEI       11
`define MIPE_BIT_LCOF      13

`define MIPE_PEND_RST      32'h0000_0000
`define MIPE_ENAB_RST      32'h0000_0000
`define MIPE_S_MASK        32'h0000_0222
`define MIPE_PLAT_MASK     32'hffff_0000
`define MIPE_M_STD_MASK    32'h0000_0880
`define MIPE_MSW_MASK      32'h0000_0008
`define MIPE_LCOF_MASK     32'h0000_2000

`endif

// *** logic/mipe_pkg.sv ***
// Types shared by the interrupt pending/enable block.
// Constants live in mipe_defines.svh.
package mipe_pkg;
    typedef enum logic [1:0] {MIPE_PRIV_U, MIPE_PRIV_S, MIPE_PRIV_RSV, MIPE_PRIV_M} mipe_priv_t;
    typedef enum logic [1:0] {MIPE_OP_WRITE, MIPE_OP_SET, MIPE_OP_CLEAR, MIPE_OP_READ} mipe_op_t;
    typedef enum logic [1:0] {MIPE_SEL_MPEND, MIPE_SEL_MENAB, MIPE_SEL_SPEND, MIPE_SEL_SENAB}
        mipe_sel_t;
endpackage

// *** tb/mipe_src_model.sv ***
// Far-side sources: external controller lines, timer compare, software-interrupt register.
// Assumes the bench drives the command inputs at the falling clock edge.
`timescale 1ns/1ps
module mipe_src_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ext_m,
    input  wire logic        i_ext_s,
    input  wire logic        i_cmp_wr,
    input  wire logic [15:0] i_cmp_val,
    input  wire logic        i_machine_software_pending_wr,
    input  wire logic        i_machine_software_pending_val,
    output logic             o_mei,
    output logic             o_mti,
    output logic             o_msi,
    output logic             o_sei
);
    logic [15:0] mtime_q;
    logic [15:0] cmp_q;
    logic        machine_software_pending_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mtime_q <= 16'h0000;
            cmp_q   <= 16'hffff;
            machine_software_pending_q  <= 1'b0;
        end else begin
            mtime_q <= mtime_q + 16'h0001;
            if (i_cmp_wr) cmp_q <= i_cmp_val;
            if (i_machine_software_pending_wr) machine_software_pending_q <= i_machine_software_pending_val;
        end
    end
    // Level drops when the compare is rewritten past the count or the 16-bit count wraps to zero
    assign o_mti = (mtime_q >= cmp_q);
    assign o_msi = machine_software_pending_q;
    assign o_mei = i_ext_m;
    assign o_sei = i_ext_s;
endmodule // mipe_src_model

// *** tb/machine_interrupt_pending_enable_tb.sv ***
// Self-checking bench for the interrupt pending/enable core.
// Assumes mipe_core with default parameters and the source model beside it.
`timescale 1ns/1ps
`include "mipe_defines.svh"
module machine_interrupt_pending_enable_tb;
    localparam logic [31:0] SWM = 32'h0000_2222;
    localparam logic [31:0] ENM = `MIPE_PLAT_MASK | `MIPE_S_MASK | `MIPE_M_STD_MASK
        | `MIPE_MSW_MASK | `MIPE_LCOF_MASK;
    localparam mipe_pkg::mipe_sel_t MP = mipe_pkg::MIPE_SEL_MPEND, ME = mipe_pkg::MIPE_SEL_MENAB;
    localparam mipe_pkg::mipe_sel_t SP = mipe_pkg::MIPE_SEL_SPEND, SE = mipe_pkg::MIPE_SEL_SENAB;
    localparam mipe_pkg::mipe_op_t WR = mipe_pkg::MIPE_OP_WRITE, ST = mipe_pkg::MIPE_OP_SET;
    localparam mipe_pkg::mipe_op_t CL = mipe_pkg::MIPE_OP_CLEAR, RD = mipe_pkg::MIPE_OP_READ;
    logic                 clk = 1'b0, rst_n = 1'b0, mie = 1'b0, sie = 1'b0, vld = 1'b0;
    mipe_pkg::mipe_priv_t priv = mipe_pkg::MIPE_PRIV_M;
    mipe_pkg::mipe_sel_t  sel = MP;
    mipe_pkg::mipe_op_t   op = RD;
    logic [31:0]          deleg = '0, wd = '0;
    logic [31:0]          wp, we, pp, r, rd, pend, enab, got;
    logic [15:0]          plat = '0, cmpv = 16'hffff;
    logic                 ext_m = 1'b0, ext_s = 1'b0, cmp_wr = 1'b0, msw = 1'b0;
    logic                 msv = 1'b0, supervisor_software_int = 1'b0, ovf = 1'b0;
    logic                 machine_external_int, machine_timer_int, machine_software_int, supervisor_external_int, mirq, sirq;
    logic [4:0]           mcause, scause;
    integer               seed = 32'h41e1;
    int                   fail_count = 0, checked = 0, cycles = 0;

    mipe_src_model src (.i_clk(clk), .i_reset_n(rst_n), .i_ext_m(ext_m), .i_ext_s(ext_s),
        .i_cmp_wr(cmp_wr), .i_cmp_val(cmpv), .i_machine_software_pending_wr(msw), .i_machine_software_pending_val(msv),
        .o_mei(machine_external_int), .o_mti(machine_timer_int), .o_msi(machine_software_int), .o_sei(supervisor_external_int));
    mipe_core dut (.i_clk(clk), .i_reset_n(rst_n), .i_priv(priv), .i_mstatus_mie(mie),
        .i_mstatus_sie(sie), .i_deleg(deleg), .i_csr_valid(vld), .i_csr_sel(sel),
        .i_csr_op(op), .i_csr_wdata(wd), .i_machine_external_int(machine_external_int),
        .i_machine_timer_int(machine_timer_int), .i_machine_software_int(machine_software_int),
        .i_supervisor_external_int(supervisor_external_int), .i_supervisor_software_set(supervisor_software_int),
        .i_platform_int(plat), .i_overflow_flag(ovf), .o_csr_rdata(rd), .o_pending(pend),
        .o_enable(enab), .o_m_irq(mirq), .o_m_cause(mcause), .o_s_irq(sirq),
        .o_s_cause(scause));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop;
        end
    end

    task automatic check(input logic [31:0] exp, input logic [31:0] act);
        checked++;
        if (act !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Read data is the pre-write value; outputs settle two edges after the access
    task automatic acc(input mipe_pkg::mipe_sel_t s, input mipe_pkg::mipe_op_t o,
                       input logic [31:0] w);
        sel = s;
        op = o;
        wd = w;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        // Read data stands for one cycle only, so take it at the first falling edge
        got = rd;
        wt(3);
    endtask

    // Platform causes first, lowest index winning, then the fixed standard order
    function automatic logic [5:0] pick(input logic [31:0] v);
        int ord [7] = '{11, 3, 7, 9, 1, 5, 13};
        for (int i = 16; i < 32; i++) if (v[i]) return {1'b1, i[4:0]};
        foreach (ord[k]) if (v[ord[k]]) return {1'b1, ord[k][4:0]};
        return 6'h00;
    endfunction

    task automatic chk_trap(input logic [31:0] pe, input logic [31:0] ee);
        logic [5:0] m;
        logic [5:0] s;
        m = (priv != mipe_pkg::MIPE_PRIV_M || mie) ? pick(pe & ee & ~(deleg & SWM)) : 6'h00;
        s = (!m[5] && (priv == mipe_pkg::MIPE_PRIV_U || (priv == mipe_pkg::MIPE_PRIV_S && sie)))
            ? pick(pe & ee & deleg & SWM) : 6'h00;
        check({26'h0, m}, {26'h0, mirq, mirq ? mcause : 5'h00});
        check({26'h0, s}, {26'h0, sirq, sirq ? scause : 5'h00});
    endtask

    task automatic set_cmp(input logic [15:0] v);
        cmpv = v;
        cmp_wr = 1'b1;
        wt(1);
        cmp_wr = 1'b0;
        wt(7);
    endtask

    initial begin
        wt(2);
        rst_n = 1'b1;
        check(32'h0, pend);
        check(32'h0, enab);
        acc(ME, WR, 32'hffff_ffff);
        check(ENM, enab);
        acc(ME, RD, 32'h0);
        check(ENM, got);
        acc(MP, WR, 32'hffff_ffff);
        check(SWM, pend);
        acc(MP, CL, SWM);
        check(32'h0, pend);
        acc(MP, ST, 32'h20);
        check(32'h20, pend);
        acc(MP, WR, 32'h0);
        $display("pending and enable access test done");
        ext_s = 1'b1;
        wt(7);
        acc(MP, ST, 32'h0);
        check(32'h200, got);
        ext_s = 1'b0;
        wt(7);
        check(32'h0, pend);
        $display("supervisor external test done");
        mie = 1'b1;
        set_cmp(16'h0001);
        check(32'h80, pend);
        chk_trap(32'h80, ENM);
        set_cmp(16'hffff);
        check(32'h0, pend);
        ovf = 1'b1;
        wt(1);
        ovf = 1'b0;
        wt(4);
        check(32'h2000, pend);
        chk_trap(32'h2000, ENM);
        acc(MP, CL, 32'h2000);
        check(32'h0, pend);
        supervisor_software_int = 1'b1;
        wt(7);
        supervisor_software_int = 1'b0;
        wt(7);
        check(32'h2, pend);
        acc(MP, CL, 32'h2);
        $display("source test done");
        repeat (30) begin
            r = $random(seed);
            {ext_m, ext_s, msv, mie, sie} = r[4:0];
            plat = r[31:16];
            priv = (r[6:5] == 2'd2) ? mipe_pkg::MIPE_PRIV_M : mipe_pkg::mipe_priv_t'(r[6:5]);
            deleg = $random(seed);
            wp = $random(seed);
            we = (r[8:7] == 2'd0) ? 32'hffff_ffff : $random(seed);
            msw = 1'b1;
            wt(1);
            msw = 1'b0;
            acc(MP, WR, wp);
            acc(ME, WR, we);
            wt(6);
            pp = (wp & SWM) | {plat, 4'h0, ext_m, 1'b0, ext_s, 5'h00, msv, 3'h0};
            check(pp, pend);
            check(we & ENM, enab);
            chk_trap(pp, we & ENM);
            acc(SP, RD, 32'h0);
            check(pp & deleg & SWM, got);
            acc(SE, RD, 32'h0);
            check(we & ENM & deleg & SWM, got);
        end
        $display("random trap test done");
        acc(ME, WR, 32'h0);
        deleg = 32'h20;
        acc(SE, WR, 32'hffff_ffff);
        check(32'h20, enab);
        $display("supervisor view write test done");
        report_and_stop;
    end
endmodule // machine_interrupt_pending_enable_tb
